// ==== rtl/wfp_core.sv ====
// Purpose: data word field decode, byte ordering and page address forming
// Assumes: all inputs come from logic on clk; rst_n synchronous, active low
// Notes: every output is registered; the i/o bytes come two and three cycles after io_start, the rest one cycle after their inputs
`timescale 1ns/1ps
`include "wfp_map.svh"

// How it works
// - a word is 16 bits, bit 15 is the sign, 1 means negative.
// - a word sent as bytes goes out upper byte first, then lower byte.
// - a double integer takes its sign from bit 15 of the upper word.
// - float mantissa sign is msw bit 15, exponent sign is lsw bit 0.
// - exponent magnitude is lsw bits 1..7, the rest form the mantissa.
// - single float is two words, 23-bit mantissa and 7-bit exponent.
// - double float has a 55-bit mantissa and the same exponent layout.
// - negative mantissa or exponent parts are two's complement values.
// - first accumulator holds the msw, second accumulator the lsw.
// - in-page offset is instruction bits 0..9, 1024 words per page.
// - instruction bit 10 picks page zero (0) or the current page (1).
// - page zero spans 0..1777 octal and is reachable from any page.
// - 32 pages of 2000 octal words each make the 32k logical space.
// - protect active shows as the protect map register sign bit.
// - current page takes address bits 10..14 from the address reg.
// - bit 15 of the instruction word marks indirect; mar has no bit 15.
module wfp_core
  import wfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] word_in,
  input wire logic [15:0] msw_in,
  input wire logic [15:0] lsw_in,
  input wire logic [15:0] xw2_in,
  input wire logic [15:0] xw3_in,
  input wire logic dbl_prec,
  input wire logic fp_load,
  input wire logic [15:0] instr,
  input wire logic [14:0] mar,
  input wire logic addr_valid,
  input wire logic [15:0] io_word,
  input wire logic io_start,
  input wire logic map_wr,
  input wire logic [15:0] map_wdata,
  output logic word_neg,
  output logic dint_neg,
  output logic [30:0] dint_mag,
  output logic mant_neg,
  output logic exp_neg,
  output logic [6:0] exp_mag,
  output logic [7:0] exp_val,
  output logic [54:0] mant_bits,
  output logic [15:0] acc_a,
  output logic [15:0] acc_b,
  output logic [14:0] eff_addr,
  output logic [9:0] page_offs,
  output logic [4:0] page_num,
  output logic on_page_zero,
  output logic indirect,
  output logic eff_valid,
  output logic [7:0] io_byte,
  output logic io_byte_vld,
  output logic io_busy,
  output logic protect_on,
  output logic [15:0] protect_map_register
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // page forming is shared by the address path and the page reporting
  function automatic logic [14:0] form_addr(input logic [15:0] ins,
                                            input logic [14:0] m);
    logic [4:0] pg;
    pg = ins[`WFP_ZC_BIT] ? m[`WFP_PAGE_HI:`WFP_PAGE_LO] : 5'h00;
    form_addr = {pg, ins[`WFP_OFFS_W-1:0]};
  endfunction : form_addr

  // ****************************************************************
  // word format decode
  // ****************************************************************
  logic word_neg_nxt, dint_neg_nxt, mant_neg_nxt, exp_neg_nxt;
  logic [30:0] dint_mag_nxt;
  logic [6:0] exp_mag_nxt;
  logic [7:0] exp_val_nxt;
  logic [54:0] mant_bits_nxt;
  logic [15:0] acc_a_nxt, acc_b_nxt;

  // fields are raw bit groups; signed parts stay two's complement
  always_comb begin
    word_neg_nxt = word_in[`WFP_SIGN_BIT];
    dint_neg_nxt = msw_in[`WFP_SIGN_BIT];
    dint_mag_nxt = {msw_in[14:0], lsw_in};
    mant_neg_nxt = msw_in[`WFP_SIGN_BIT];
    exp_neg_nxt = dbl_prec ? xw3_in[`WFP_EXP_SIGN_BIT]
                           : lsw_in[`WFP_EXP_SIGN_BIT];
    exp_mag_nxt = dbl_prec ? xw3_in[`WFP_EXP_HI:`WFP_EXP_LO]
                           : lsw_in[`WFP_EXP_HI:`WFP_EXP_LO];
    // sign bit placed above the 7-bit field keeps the two's complement value
    exp_val_nxt = {exp_neg_nxt, exp_mag_nxt};
    if (dbl_prec) begin
      mant_bits_nxt = {msw_in[14:0], lsw_in, xw2_in, xw3_in[15:8]};
    end else begin
      mant_bits_nxt = {32'h00000000, msw_in[14:0], lsw_in[15:8]};
    end
    acc_a_nxt = acc_a;
    acc_b_nxt = acc_b;
    if (fp_load) begin
      acc_a_nxt = msw_in;
      acc_b_nxt = lsw_in;
    end
  end

  // registers only; every field is one cycle behind its input words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_neg <= 1'b0;
      dint_neg <= 1'b0;
      dint_mag <= 31'h0;
      mant_neg <= 1'b0;
      exp_neg <= 1'b0;
      exp_mag <= 7'h00;
      exp_val <= 8'h00;
      mant_bits <= 55'h0;
      acc_a <= 16'h0000;
      acc_b <= 16'h0000;
    end else begin
      word_neg <= word_neg_nxt;
      dint_neg <= dint_neg_nxt;
      dint_mag <= dint_mag_nxt;
      mant_neg <= mant_neg_nxt;
      exp_neg <= exp_neg_nxt;
      exp_mag <= exp_mag_nxt;
      exp_val <= exp_val_nxt;
      mant_bits <= mant_bits_nxt;
      acc_a <= acc_a_nxt;
      acc_b <= acc_b_nxt;
    end
  end

  // ****************************************************************
  // page addressing
  // ****************************************************************
  logic [14:0] eff_addr_nxt;
  logic indirect_nxt, on_pz_nxt, eff_valid_nxt;

  // page zero is reachable from any page, the current page directly too; other pages need indirection
  always_comb begin
    eff_addr_nxt = form_addr(instr, mar);
    on_pz_nxt = (eff_addr_nxt <= `WFP_PAGE_ZERO_LAST);
    indirect_nxt = instr[`WFP_IND_BIT];
    eff_valid_nxt = addr_valid;
  end

  // after reset the address path points at word zero of page zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eff_addr <= 15'h0000;
      page_offs <= 10'h000;
      page_num <= 5'h00;
      on_page_zero <= 1'b1;
      indirect <= 1'b0;
      eff_valid <= 1'b0;
    end else begin
      eff_addr <= eff_addr_nxt;
      page_offs <= eff_addr_nxt[9:0];
      page_num <= eff_addr_nxt[14:10];
      on_page_zero <= on_pz_nxt;
      indirect <= indirect_nxt;
      eff_valid <= eff_valid_nxt;
    end
  end

  // ****************************************************************
  // byte serialiser for i/o
  // ****************************************************************
  wfp_io_st_t io_st_r, io_st_nxt;
  logic [15:0] io_hold_r, io_hold_nxt;
  logic [7:0] io_byte_nxt;
  logic io_vld_nxt, io_busy_nxt;

  // a start while busy is ignored so a word is never split
  always_comb begin
    io_st_nxt = io_st_r;
    io_hold_nxt = io_hold_r;
    io_byte_nxt = io_byte;
    io_vld_nxt = 1'b0;
    case (io_st_r)
      WFP_IDLE: begin
        if (io_start) begin
          io_hold_nxt = io_word;
          io_st_nxt = WFP_HI;
        end
      end
      WFP_HI: begin
        io_byte_nxt = io_hold_r[15:8];
        io_vld_nxt = 1'b1;
        io_st_nxt = WFP_LO;
      end
      WFP_LO: begin
        io_byte_nxt = io_hold_r[7:0];
        io_vld_nxt = 1'b1;
        io_st_nxt = WFP_IDLE;
      end
      default: io_st_nxt = WFP_IDLE;
    endcase
    io_busy_nxt = (io_st_nxt != WFP_IDLE);
  end

  // a reset mid-word drops the pending low byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_st_r <= WFP_IDLE;
      io_hold_r <= 16'h0000;
      io_byte <= 8'h00;
      io_byte_vld <= 1'b0;
      io_busy <= 1'b0;
    end else begin
      io_st_r <= io_st_nxt;
      io_hold_r <= io_hold_nxt;
      io_byte <= io_byte_nxt;
      io_byte_vld <= io_vld_nxt;
      io_busy <= io_busy_nxt;
    end
  end

  // ****************************************************************
  // protect map register
  // ****************************************************************
  logic [15:0] pmr_nxt;

  // software may rewrite the whole word, sign bit included
  always_comb begin
    pmr_nxt = map_wr ? map_wdata : protect_map_register;
  end

  // flag follows the written sign bit in the same cycle as the word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      protect_map_register <= 16'h0000;
      protect_on <= 1'b0;
    end else begin
      protect_map_register <= pmr_nxt;
      protect_on <= pmr_nxt[`WFP_SIGN_BIT];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_hi_byte;
    io_byte_vld && io_byte == $past(io_word[15:8], 2);
  endsequence
  sequence s_lo_byte;
    io_byte_vld && io_byte == $past(io_word[7:0], 3);
  endsequence

  a_byte_order_hi: assert property (@(posedge clk) disable iff (!rst_n)
    io_start && !io_busy && io_st_r == WFP_IDLE |-> ##2 s_hi_byte ##1 s_lo_byte)
    else $error("byte order wrong");
  a_two_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    io_byte_vld ##1 io_byte_vld |=> !io_byte_vld)
    else $error("more than two bytes per word");
  a_page_zero_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !instr[10] |=> eff_addr[14:10] == 5'h00)
    else $error("page zero not forced");
  a_cur_page_sel: assert property (@(posedge clk) disable iff (!rst_n)
    instr[10] |=> eff_addr[14:10] == $past(mar[14:10]))
    else $error("current page not taken");
  a_offset_copy: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> page_offs == $past(instr[9:0]))
    else $error("offset wrong");
  a_page_number: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> page_num == eff_addr[14:10] && page_offs == eff_addr[9:0])
    else $error("page number wrong");
  a_indirect_bit: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> indirect == $past(instr[15]))
    else $error("indirect bit wrong");
  a_word_sign: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> word_neg == $past(word_in[15]))
    else $error("sign wrong");
  a_dint_sign: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> dint_neg == $past(msw_in[15]) &&
      dint_mag == {$past(msw_in[14:0]), $past(lsw_in)})
    else $error("double integer wrong");
  a_exp_fields: assert property (@(posedge clk) disable iff (!rst_n)
    !dbl_prec |=> exp_mag == $past(lsw_in[7:1]) && exp_neg == $past(lsw_in[0]))
    else $error("exponent wrong");
  a_exp_double: assert property (@(posedge clk) disable iff (!rst_n)
    dbl_prec |=> exp_mag == $past(xw3_in[7:1]) &&
      exp_neg == $past(xw3_in[0]))
    else $error("double exponent wrong");
  a_mant_single: assert property (@(posedge clk) disable iff (!rst_n)
    !dbl_prec |=> mant_bits[54:23] == 32'h00000000 &&
      mant_bits[22:0] == {$past(msw_in[14:0]), $past(lsw_in[15:8])})
    else $error("single mantissa wrong");
  a_mant_double: assert property (@(posedge clk) disable iff (!rst_n)
    dbl_prec |=> mant_bits == {$past(msw_in[14:0]), $past(lsw_in),
      $past(xw2_in), $past(xw3_in[15:8])})
    else $error("double mantissa wrong");
  a_mant_sign: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mant_neg == $past(msw_in[15]))
    else $error("mantissa sign wrong");
  a_acc_split: assert property (@(posedge clk) disable iff (!rst_n)
    fp_load |=> acc_a == $past(msw_in) && acc_b == $past(lsw_in))
    else $error("accumulator split wrong");
  a_protect_sign: assert property (@(posedge clk) disable iff (!rst_n)
    map_wr |=> protect_on == $past(map_wdata[15]))
    else $error("protect flag wrong");
  a_page_zero_rng: assert property (@(posedge clk) disable iff (!rst_n)
    !instr[10] |=> on_page_zero)
    else $error("page zero range wrong");

endmodule : wfp_core

// ==== rtl/wfp_map.svh ====
// Purpose: constants for the word format and page addressing block
// Assumes: 16-bit words, 15-bit logical addresses
// Notes: definitions only
`ifndef WFP_MAP_SVH
`define WFP_MAP_SVH
`define WFP_WORD_W 16
`define WFP_SIGN_BIT 15
`define WFP_ADDR_W 15
`define WFP_OFFS_W 10
`define WFP_PAGE_LO 10
`define WFP_PAGE_HI 14
`define WFP_ZC_BIT 10
`define WFP_IND_BIT 15
`define WFP_EXP_SIGN_BIT 0
`define WFP_EXP_LO 1
`define WFP_EXP_HI 7
`define WFP_PAGE_ZERO_LAST 15'h03ff
`define WFP_PAGES 32
`endif

// ==== rtl/wfp_pkg.sv ====
// Purpose: types for the word format and page addressing block
// Assumes: nothing beyond the map header
// Notes: types only
package wfp_pkg;
  typedef enum logic [1:0] {WFP_IDLE, WFP_HI, WFP_LO} wfp_io_st_t;
  typedef logic [15:0] wfp_word_t;
endpackage : wfp_pkg

// ==== testbench/wfp_dec_model.sv ====
// Purpose: stand-in for the instruction decoder and memory address path
// Assumes: requests launched just after a rising clk edge
// Notes: released lines show the inverse of the last value, never a hold
`timescale 1ns/1ps

module wfp_dec_model (
  input wire logic clk,
  output logic [15:0] instr,
  output logic [14:0] mar,
  output logic addr_valid
);
  initial begin
    instr = 16'h0000;
    mar = 15'h0000;
    addr_valid = 1'b0;
  end

  // one memory reference, held across exactly one sampling edge
  task issue(input logic [15:0] i, input logic [14:0] m);
    @(posedge clk);
    #1;
    instr = i;
    mar = m;
    addr_valid = 1'b1;
    @(posedge clk);
    #1;
    // inverted so a core that misses the edge cannot pass by luck
    addr_valid = 1'b0;
    instr = ~i;
    mar = ~m;
  endtask : issue
endmodule : wfp_dec_model

// ==== testbench/word_format_page_addressing_test.sv ====
// Purpose: self-checking bench for wfp_core
// Assumes: decode, address and map outputs registered one cycle after their inputs
// Notes: address and protect map cases run from a table, the rest by hand
`timescale 1ns/1ps

module word_format_page_addressing_test
  import wfp_pkg::*;
;
  typedef struct {logic [15:0] i; logic [14:0] m; logic [14:0] e;} wfp_row_t;
  logic clk, rst_n, dbl_prec, fp_load, addr_valid, io_start, map_wr;
  logic [15:0] word_in, msw_in, lsw_in, xw2_in, xw3_in, instr, io_word;
  logic [15:0] map_wdata, acc_a, acc_b, protect_map_register;
  logic [14:0] mar, eff_addr;
  logic word_neg, dint_neg, mant_neg, exp_neg, on_page_zero, indirect;
  logic eff_valid, io_byte_vld, io_busy, protect_on;
  logic [30:0] dint_mag;
  logic [6:0] exp_mag;
  logic [7:0] exp_val, io_byte;
  logic [54:0] mant_bits;
  logic [9:0] page_offs;
  logic [4:0] page_num;
  logic [7:0] got [2];
  int error_cnt = 0;
  int check_count = 0;
  int n;
  // page zero edges, current page with indirect, last word of space
  wfp_row_t rows [4] = '{
    '{16'h03ff, 15'h7c00, 15'h03ff},
    '{16'h8401, 15'h0800, 15'h0801},
    '{16'h07ff, 15'h7fff, 15'h7fff},
    '{16'h8000, 15'h1234, 15'h0000}};

  wfp_core i_wfp_core (.clk, .rst_n, .word_in, .msw_in, .lsw_in, .xw2_in,
    .xw3_in, .dbl_prec, .fp_load, .instr, .mar, .addr_valid, .io_word,
    .io_start, .map_wr, .map_wdata, .word_neg, .dint_neg, .dint_mag,
    .mant_neg, .exp_neg, .exp_mag, .exp_val, .mant_bits, .acc_a, .acc_b,
    .eff_addr, .page_offs, .page_num, .on_page_zero, .indirect, .eff_valid,
    .io_byte, .io_byte_vld, .io_busy, .protect_on, .protect_map_register);
  wfp_dec_model i_wfp_dec_model (.clk, .instr, .mar, .addr_valid);

  always #50 clk = ~clk;

  // ***************
  // shared tasks
  // ***************
  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task reset_chk;
    chk("on_page_zero", 1'b1, on_page_zero);
    chk("eff_addr", 15'h0000, eff_addr);
    chk("io_busy", 1'b0, io_busy);
    chk("protect_map_register", 16'h0000, protect_map_register);
    chk("protect_on", 1'b0, protect_on);
    chk("acc_a", 16'h0000, acc_a);
  endtask : reset_chk

  // load up to four words; exponent word is lsw or the fourth word
  task fp(input logic [15:0] a, b, c, d, input logic dbl);
    logic [15:0] x;
    @(posedge clk);
    #1;
    {word_in, msw_in, lsw_in, xw2_in, xw3_in} = {a, a, b, c, d};
    dbl_prec = dbl;
    fp_load = 1'b1;
    @(posedge clk);
    #1;
    fp_load = 1'b0;
    x = dbl ? d : b;
    chk("eff_valid", 1'b0, eff_valid);
    chk("word_neg", a[15], word_neg);
    chk("dint_neg", a[15], dint_neg);
    chk("dint_mag", {a[14:0], b}, dint_mag);
    chk("mant_neg", a[15], mant_neg);
    chk("exp_neg", x[0], exp_neg);
    chk("exp_mag", x[7:1], exp_mag);
    chk("exp_val", {x[0], x[7:1]}, exp_val);
    chk("acc_a", a, acc_a);
    chk("acc_b", b, acc_b);
    if (dbl) begin
      chk("mant_bits", {a[14:0], b, c, d[15:8]}, mant_bits);
    end else begin
      chk("mant_bits", {a[14:0], b[15:8]}, mant_bits);
    end
  endtask : fp

  task print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ***************
  // main sequence
  // ***************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {word_in, msw_in, lsw_in, xw2_in, xw3_in, io_word} = '0;
    {dbl_prec, fp_load, io_start, map_wr} = '0;
    map_wdata = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    reset_chk();
    rst_n = 1'b1;
    foreach (rows[k]) begin
      i_wfp_dec_model.issue(rows[k].i, rows[k].m);
      chk("eff_addr", rows[k].e, eff_addr);
      chk("page_offs", rows[k].i[9:0], page_offs);
      chk("page_num", rows[k].e[14:10], page_num);
      chk("on_page_zero", !rows[k].i[10], on_page_zero);
      chk("indirect", rows[k].i[15], indirect);
      chk("eff_valid", 1'b1, eff_valid);
    end
    fp(16'h8001, 16'h12ff, 16'h5a5a, 16'hc301, 1'b0);
    fp(16'h8001, 16'h12ff, 16'h5a5a, 16'hc301, 1'b1);
    fp(16'h7fff, 16'h00fe, 16'ha5a5, 16'h3cff, 1'b1);
    // start held over two edges: the second lands while busy
    io_word = 16'hab12;
    io_start = 1'b1;
    n = 0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      if (k == 0) chk("io_busy", 1'b1, io_busy);
      if (k == 1) io_start = 1'b0;
      if (io_byte_vld === 1'b1 && n < 2) got[n] = io_byte;
      if (io_byte_vld === 1'b1) n++;
    end
    chk("io_busy", 1'b0, io_busy);
    chk("io_count", 2, n);
    chk("io_hi", 8'hab, got[0]);
    chk("io_lo", 8'h12, got[1]);
    foreach (rows[k]) begin
      @(posedge clk);
      #1;
      map_wr = 1'b1;
      map_wdata = rows[k].i ^ 16'h8000;
      @(posedge clk);
      #1;
      map_wr = 1'b0;
      chk("protect_map", rows[k].i ^ 16'h8000, protect_map_register);
      chk("protect_on", !rows[k].i[15], protect_on);
    end
    // second reset in mid-run must clear the map again
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    reset_chk();
    rst_n = 1'b1;
    print_verdict();
  end
endmodule : word_format_page_addressing_test
